// ===== logic/cdpo_pkg.sv
// constants, register map and helpers for the channel divider block
// assumes an Avalon-MM master with byte addresses and 32-bit data
package cdpo_pkg;

    // ****************************************
    // register indexes (byte address = 4 * index)
    // ****************************************
    localparam logic [8:0] IDX_DIV0_CYC   = 9'h190;
    localparam logic [8:0] IDX_DIV0_OFS   = 9'h191;
    localparam logic [8:0] IDX_DIV0_DUTY  = 9'h192;
    localparam logic [8:0] IDX_DIV1_CYC   = 9'h196;
    localparam logic [8:0] IDX_DIV1_OFS   = 9'h197;
    localparam logic [8:0] IDX_DIV1_DUTY  = 9'h198;
    localparam logic [8:0] IDX_DIV2_S1    = 9'h199;
    localparam logic [8:0] IDX_DIV2_S2    = 9'h19B;
    localparam logic [8:0] IDX_DIV2_BYP   = 9'h19C;
    localparam logic [8:0] IDX_DIV2_DUTY  = 9'h19D;
    localparam logic [8:0] IDX_DIV3_S1    = 9'h19E;
    localparam logic [8:0] IDX_DIV3_S2    = 9'h1A0;
    localparam logic [8:0] IDX_DIV3_BYP   = 9'h1A1;
    localparam logic [8:0] IDX_DIV3_DUTY  = 9'h1A2;
    localparam logic [8:0] IDX_OUT_MODE   = 9'h1F0;
    localparam logic [8:0] IDX_SYNC_CTRL  = 9'h1F1;
    localparam logic [8:0] IDX_STATUS     = 9'h1F2;

    // ****************************************
    // storage slots
    // ****************************************
    localparam int         NUM_REGS       = 15;
    localparam int         NUM_STAGES     = 6;
    localparam logic [4:0] SLOT_DIV0_CYC  = 5'h00;
    localparam logic [4:0] SLOT_DIV0_OFS  = 5'h01;
    localparam logic [4:0] SLOT_DIV0_DUTY = 5'h02;
    localparam logic [4:0] SLOT_DIV1_CYC  = 5'h03;
    localparam logic [4:0] SLOT_DIV1_OFS  = 5'h04;
    localparam logic [4:0] SLOT_DIV1_DUTY = 5'h05;
    localparam logic [4:0] SLOT_DIV2_S1   = 5'h06;
    localparam logic [4:0] SLOT_DIV2_S2   = 5'h07;
    localparam logic [4:0] SLOT_DIV2_BYP  = 5'h08;
    localparam logic [4:0] SLOT_DIV2_DUTY = 5'h09;
    localparam logic [4:0] SLOT_DIV3_S1   = 5'h0A;
    localparam logic [4:0] SLOT_DIV3_S2   = 5'h0B;
    localparam logic [4:0] SLOT_DIV3_BYP  = 5'h0C;
    localparam logic [4:0] SLOT_DIV3_DUTY = 5'h0D;
    localparam logic [4:0] SLOT_OUT_MODE  = 5'h0E;
    localparam logic [4:0] SLOT_SYNC      = 5'h0F;
    localparam logic [4:0] SLOT_STATUS    = 5'h10;
    localparam logic [4:0] SLOT_NONE      = 5'h1F;

    // ****************************************
    // field positions, reset values, weights
    // ****************************************
    localparam int         LOW_LSB        = 4;
    localparam int         HIGH_LSB       = 0;
    localparam int         BYPASS_BIT     = 7;
    localparam int         START_HIGH_BIT = 4;
    localparam int         OFFSET_CNT_LSB = 0;
    localparam int         S1_BYP_BIT     = 4;
    localparam int         S2_BYP_BIT     = 5;
    localparam int         FIX_OFF_BIT    = 0;
    localparam int         SYNC_BIT       = 0;
    localparam int         B_EN_LSB       = 4;
    localparam logic [7:0] RST_REG        = 8'h00;
    localparam logic [4:0] FLAG_WEIGHT    = 5'h10;
    localparam logic [4:0] PHI_DIRECT_MAX = 5'h0F;

    typedef enum logic {BUS_IDLE, BUS_DONE} cdpo_bus_e;

    // index to slot; anything else is unmapped
    function automatic logic [4:0] cdpo_slot_of(input logic [8:0] idx);
        if (idx == IDX_DIV0_CYC) return SLOT_DIV0_CYC;
        else if (idx == IDX_DIV0_OFS) return SLOT_DIV0_OFS;
        else if (idx == IDX_DIV0_DUTY) return SLOT_DIV0_DUTY;
        else if (idx == IDX_DIV1_CYC) return SLOT_DIV1_CYC;
        else if (idx == IDX_DIV1_OFS) return SLOT_DIV1_OFS;
        else if (idx == IDX_DIV1_DUTY) return SLOT_DIV1_DUTY;
        else if (idx == IDX_DIV2_S1) return SLOT_DIV2_S1;
        else if (idx == IDX_DIV2_S2) return SLOT_DIV2_S2;
        else if (idx == IDX_DIV2_BYP) return SLOT_DIV2_BYP;
        else if (idx == IDX_DIV2_DUTY) return SLOT_DIV2_DUTY;
        else if (idx == IDX_DIV3_S1) return SLOT_DIV3_S1;
        else if (idx == IDX_DIV3_S2) return SLOT_DIV3_S2;
        else if (idx == IDX_DIV3_BYP) return SLOT_DIV3_BYP;
        else if (idx == IDX_DIV3_DUTY) return SLOT_DIV3_DUTY;
        else if (idx == IDX_OUT_MODE) return SLOT_OUT_MODE;
        else if (idx == IDX_SYNC_CTRL) return SLOT_SYNC;
        else if (idx == IDX_STATUS) return SLOT_STATUS;
        else return SLOT_NONE;
    endfunction

    // delay in input cycles from start-high flag, offset count, low field
    function automatic logic [4:0] cdpo_phase_delay(input logic       level_flag,
                                                    input logic [3:0] offset_count,
                                                    input logic [3:0] m);
        logic [4:0] phi;
        phi = {level_flag, offset_count};
        if (phi <= PHI_DIRECT_MAX) return phi;
        else return phi - FLAG_WEIGHT + {1'b0, m} + 5'h01;
    endfunction

endpackage

// ===== logic/cdpo_channel_divider.sv
// channel dividers 0..3, coarse phase offset on dividers 0 and 1, sync and Avalon-MM registers
// assumes dist_clk_in is the divider input clock, slow enough to be sampled by clock
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module cdpo_channel_divider
    import cdpo_pkg::*;
#(
    parameter int ADDR_W = 11
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    input  wire logic              dist_clk_in,
    output logic                   div0_out,
    output logic                   div1_out,
    output logic      [3:0]        differential_outputs_a,
    output logic      [3:0]        differential_outputs_b
);

    // ****************************************
    // declarations
    // ****************************************
    cdpo_bus_e   bus_state_reg;
    logic        waitrequest_reg;
    logic [31:0] readdata_reg;
    logic [7:0]  reg_file_reg [NUM_REGS];
    logic        sync_pending_reg;
    logic        dist_q_reg;
    logic        dist_prev_reg;
    logic        in_rise;
    logic        sync_fire;
    logic        wr_fire;
    logic [4:0]  acc_slot;
    logic [7:0]  rd_byte;

    logic [NUM_STAGES-1:0] run_reg;
    logic [NUM_STAGES-1:0] started_reg;
    logic [NUM_STAGES-1:0] lvl_reg;
    logic [NUM_STAGES-1:0] rise_pulse_reg;
    logic [3:0]            cnt_reg [NUM_STAGES];
    logic [4:0]            dly_cnt_reg [NUM_STAGES];

    logic [3:0]            hi_f [NUM_STAGES];
    logic [3:0]            lo_f [NUM_STAGES];
    logic [4:0]            dly_val [NUM_STAGES];
    logic [NUM_STAGES-1:0] byp;
    logic [NUM_STAGES-1:0] tick;
    logic                  eff0;
    logic                  eff1;
    logic                  eff2;
    logic                  eff3;

    logic        div0_out_reg;
    logic        div1_out_reg;
    logic [3:0]  out_a_reg;
    logic [3:0]  out_b_reg;

    // ****************************************
    // input clock sampling
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dist_q_reg    <= 1'b0;
            dist_prev_reg <= 1'b0;
        end else begin
            dist_q_reg    <= dist_clk_in;
            dist_prev_reg <= dist_q_reg;
        end
    end

    // one input cycle per rising edge of the distribution clock
    assign in_rise = dist_q_reg & ~dist_prev_reg;

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    // every access answers after exactly one wait cycle
    assign acc_slot = (address[1:0] == 2'h0) ? cdpo_slot_of(address[10:2]) : SLOT_NONE;
    assign wr_fire  = write && (bus_state_reg == BUS_DONE);

    always_comb begin
        rd_byte = 8'h00;
        if (acc_slot == SLOT_STATUS) begin
            rd_byte = {lvl_reg, run_reg[0], sync_pending_reg};
        end else if (acc_slot < SLOT_SYNC) begin
            rd_byte = reg_file_reg[acc_slot[3:0]];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_state_reg   <= BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg    <= 32'h00000000;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (read || write) begin
                        bus_state_reg   <= BUS_DONE;
                        waitrequest_reg <= 1'b0;
                        readdata_reg    <= read ? {24'h000000, rd_byte} : 32'h00000000;
                    end
                end
                default: begin
                    bus_state_reg   <= BUS_IDLE;
                    waitrequest_reg <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // register file
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                reg_file_reg[r] <= RST_REG;
            end
        end else if (wr_fire && byteenable[0] && (acc_slot < SLOT_SYNC)) begin
            reg_file_reg[acc_slot[3:0]] <= writedata[7:0];
        end
    end

    // pending from reset so the outputs align at power-up; a new request wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_pending_reg <= 1'b1;
        end else begin
            sync_pending_reg <= (sync_pending_reg & ~sync_fire)
                              | (wr_fire && byteenable[0] && (acc_slot == SLOT_SYNC) && writedata[SYNC_BIT]);
        end
    end

    // offsets are only sampled here, so writes to the offset fields never move a phase without a sync
    assign sync_fire = sync_pending_reg & in_rise;

    // ****************************************
    // stage configuration
    // ****************************************
    function automatic logic [7:0] cyc_of(input int s);
        case (s)
            0: return reg_file_reg[SLOT_DIV0_CYC[3:0]];
            1: return reg_file_reg[SLOT_DIV1_CYC[3:0]];
            2: return reg_file_reg[SLOT_DIV2_S1[3:0]];
            3: return reg_file_reg[SLOT_DIV2_S2[3:0]];
            4: return reg_file_reg[SLOT_DIV3_S1[3:0]];
            default: return reg_file_reg[SLOT_DIV3_S2[3:0]];
        endcase
    endfunction

    always_comb begin
        logic [7:0] cyc;
        logic       fix_off;
        logic [4:0] sum;
        cyc     = 8'h00;
        fix_off = 1'b0;
        sum     = 5'h00;
        byp[0]  = reg_file_reg[SLOT_DIV0_OFS[3:0]][BYPASS_BIT];
        byp[1]  = reg_file_reg[SLOT_DIV1_OFS[3:0]][BYPASS_BIT];
        byp[2]  = reg_file_reg[SLOT_DIV2_BYP[3:0]][S1_BYP_BIT];
        byp[3]  = reg_file_reg[SLOT_DIV2_BYP[3:0]][S2_BYP_BIT];
        byp[4]  = reg_file_reg[SLOT_DIV3_BYP[3:0]][S1_BYP_BIT];
        byp[5]  = reg_file_reg[SLOT_DIV3_BYP[3:0]][S2_BYP_BIT];
        for (int s = 0; s < NUM_STAGES; s++) begin
            cyc = cyc_of(s);
            case (s)
                0: fix_off = reg_file_reg[SLOT_DIV0_DUTY[3:0]][FIX_OFF_BIT];
                1: fix_off = reg_file_reg[SLOT_DIV1_DUTY[3:0]][FIX_OFF_BIT];
                2, 3: fix_off = reg_file_reg[SLOT_DIV2_DUTY[3:0]][FIX_OFF_BIT];
                default: fix_off = reg_file_reg[SLOT_DIV3_DUTY[3:0]][FIX_OFF_BIT];
            endcase
            // whole-cycle balancing only: an odd ratio keeps one extra low cycle
            sum = {1'b0, cyc[LOW_LSB+:4]} + {1'b0, cyc[HIGH_LSB+:4]};
            if (fix_off) begin
                hi_f[s] = cyc[HIGH_LSB+:4];
                lo_f[s] = cyc[LOW_LSB+:4];
            end else begin
                hi_f[s] = sum[4:1];
                lo_f[s] = 4'(sum - {1'b0, sum[4:1]});
            end
            // coarse offset applies to dividers 0 and 1 only
            if (s < 2) begin
                dly_val[s] = cdpo_phase_delay(
                             reg_file_reg[(s == 0) ? SLOT_DIV0_OFS[3:0] : SLOT_DIV1_OFS[3:0]][START_HIGH_BIT],
                             reg_file_reg[(s == 0) ? SLOT_DIV0_OFS[3:0] : SLOT_DIV1_OFS[3:0]][OFFSET_CNT_LSB+:4],
                             cyc[LOW_LSB+:4]);
            end else begin
                dly_val[s] = 5'h00;
            end
        end
    end

    // second stage counts first-stage periods; a bypassed first stage passes input cycles
    always_comb begin
        tick    = {NUM_STAGES{in_rise}};
        tick[3] = byp[2] ? in_rise : rise_pulse_reg[2];
        tick[5] = byp[4] ? in_rise : rise_pulse_reg[4];
    end

    // ****************************************
    // stage counters
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_reg        <= '0;
            started_reg    <= '0;
            lvl_reg        <= '0;
            rise_pulse_reg <= '0;
            for (int s = 0; s < NUM_STAGES; s++) begin
                cnt_reg[s]     <= 4'h0;
                dly_cnt_reg[s] <= 5'h00;
            end
        end else begin
            for (int s = 0; s < NUM_STAGES; s++) begin
                rise_pulse_reg[s] <= 1'b0;
                if (sync_fire) begin
                    run_reg[s]     <= 1'b1;
                    started_reg[s] <= 1'b0;
                    lvl_reg[s]     <= 1'b0;
                    cnt_reg[s]     <= 4'h0;
                    dly_cnt_reg[s] <= dly_val[s];
                end else if (byp[s]) begin
                    // counting circuit held idle while bypassed
                    started_reg[s] <= 1'b0;
                    lvl_reg[s]     <= 1'b0;
                    cnt_reg[s]     <= 4'h0;
                end else if (run_reg[s] && tick[s]) begin
                    if (dly_cnt_reg[s] != 5'h00) begin
                        dly_cnt_reg[s] <= dly_cnt_reg[s] - 5'h01;
                    end else if (!started_reg[s] || (!lvl_reg[s] && (cnt_reg[s] == 4'h0))) begin
                        lvl_reg[s]        <= 1'b1;
                        cnt_reg[s]        <= hi_f[s];
                        started_reg[s]    <= 1'b1;
                        rise_pulse_reg[s] <= 1'b1;
                    end else if (cnt_reg[s] != 4'h0) begin
                        cnt_reg[s] <= cnt_reg[s] - 4'h1;
                    end else begin
                        lvl_reg[s] <= 1'b0;
                        cnt_reg[s] <= lo_f[s];
                    end
                end
            end
        end
    end

    // ****************************************
    // output selection
    // ****************************************
    always_comb begin
        eff0 = byp[0] ? dist_q_reg : lvl_reg[0];
        eff1 = byp[1] ? dist_q_reg : lvl_reg[1];
        eff2 = byp[3] ? (byp[2] ? dist_q_reg : lvl_reg[2]) : lvl_reg[3];
        eff3 = byp[5] ? (byp[4] ? dist_q_reg : lvl_reg[4]) : lvl_reg[5];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div0_out_reg <= 1'b0;
            div1_out_reg <= 1'b0;
            out_a_reg    <= 4'h0;
            out_b_reg    <= 4'h0;
        end else begin
            div0_out_reg <= eff0;
            div1_out_reg <= eff1;
            for (int k = 0; k < 4; k++) begin
                out_a_reg[k] <= (k < 2) ? eff2 : eff3;
                if (reg_file_reg[SLOT_OUT_MODE[3:0]][k]) begin
                    // single-ended pair: B only when enabled
                    out_b_reg[k] <= reg_file_reg[SLOT_OUT_MODE[3:0]][B_EN_LSB + k] & ((k < 2) ? eff2 : eff3);
                end else begin
                    out_b_reg[k] <= ~((k < 2) ? eff2 : eff3);
                end
            end
        end
    end

    assign readdata               = readdata_reg;
    assign waitrequest            = waitrequest_reg;
    assign div0_out               = div0_out_reg;
    assign div1_out               = div1_out_reg;
    assign differential_outputs_a = out_a_reg;
    assign differential_outputs_b = out_b_reg;

    // ****************************************
    // checks
    // ****************************************
    logic       first_pend_reg;
    logic       seen_rise_reg;
    logic [4:0] dly_set_reg;
    logic [5:0] tk_cnt_reg;
    logic [4:0] hi_cnt_reg;
    logic [5:0] per_cnt_reg;
    logic       lvl0_q_reg;
    logic [3:0] hi_set_reg;
    logic [3:0] lo_set_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_pend_reg <= 1'b0;
            seen_rise_reg  <= 1'b0;
            dly_set_reg    <= 5'h00;
            tk_cnt_reg     <= 6'h00;
            hi_cnt_reg     <= 5'h00;
            per_cnt_reg    <= 6'h00;
        end else if (sync_fire) begin
            first_pend_reg <= 1'b1;
            seen_rise_reg  <= 1'b0;
            dly_set_reg    <= dly_val[0];
            tk_cnt_reg     <= 6'h00;
        end else begin
            if (byp[0]) begin
                seen_rise_reg <= 1'b0;
            end else if (rise_pulse_reg[0]) begin
                first_pend_reg <= 1'b0;
                seen_rise_reg  <= 1'b1;
                hi_cnt_reg     <= 5'h00;
                per_cnt_reg    <= 6'h00;
            end else if (tick[0] && !byp[0]) begin
                hi_cnt_reg  <= hi_cnt_reg + {4'h0, lvl_reg[0]};
                per_cnt_reg <= per_cnt_reg + 6'h01;
                tk_cnt_reg  <= tk_cnt_reg + {5'h00, first_pend_reg};
            end
        end
    end

    // counts really loaded, so a field written mid-period is not misjudged
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            {lvl0_q_reg, hi_set_reg, lo_set_reg} <= 9'h000;
        end else begin
            lvl0_q_reg <= lvl_reg[0];
            if (rise_pulse_reg[0]) hi_set_reg <= cnt_reg[0];
            if (lvl0_q_reg && !lvl_reg[0]) lo_set_reg <= cnt_reg[0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_bus_req;
        (read || write) && (bus_state_reg == BUS_IDLE);
    endsequence

    sequence s_bus_answer;
        !waitrequest_reg ##1 waitrequest_reg;
    endsequence

    a_bus_one_wait: assert property (s_bus_req |=> s_bus_answer)
        else $error("bus answer not after one wait cycle");

    a_delay_direct: assert property (
        sync_fire && !reg_file_reg[SLOT_DIV0_OFS[3:0]][START_HIGH_BIT]
        |=> dly_cnt_reg[0] == {1'b0, $past(reg_file_reg[SLOT_DIV0_OFS[3:0]][OFFSET_CNT_LSB+:4])})
        else $error("direct offset not loaded");

    a_delay_start_high: assert property (
        sync_fire && reg_file_reg[SLOT_DIV0_OFS[3:0]][START_HIGH_BIT]
        |=> dly_cnt_reg[0] == 5'({1'b0, $past(reg_file_reg[SLOT_DIV0_OFS[3:0]][OFFSET_CNT_LSB+:4])}
                                + {1'b0, $past(reg_file_reg[SLOT_DIV0_CYC[3:0]][LOW_LSB+:4])} + 5'h01))
        else $error("start-high offset wrong");

    a_offset_needs_sync: assert property (
        !sync_fire |=> dly_cnt_reg[0] <= $past(dly_cnt_reg[0]))
        else $error("delay moved without sync");

    a_first_edge_delay: assert property (
        rise_pulse_reg[0] && first_pend_reg |-> tk_cnt_reg == {1'b0, dly_set_reg} + 6'h01)
        else $error("first edge not at programmed delay");

    a_high_width: assert property (
        $fell(lvl_reg[0]) && !$past(sync_fire) && !byp[0]
        |-> hi_cnt_reg == {1'b0, hi_set_reg} + 5'h01)
        else $error("high time differs from field plus one");

    a_period_ratio: assert property (
        rise_pulse_reg[0] && seen_rise_reg |-> per_cnt_reg == 6'(hi_set_reg) + 6'(lo_set_reg) + 6'h02)
        else $error("period differs from high plus low plus two");

    a_bypass_follow: assert property (
        byp[0] && $past(byp[0]) |-> div0_out_reg == $past(dist_q_reg) && cnt_reg[0] == 4'h0)
        else $error("bypassed divider not following input");

    a_stage2_clocked: assert property (
        !byp[2] && !byp[3] && $past(!byp[2]) && $past(!byp[3]) && !$past(sync_fire)
        && (lvl_reg[3] != $past(lvl_reg[3])) |-> $past(rise_pulse_reg[2]))
        else $error("second stage moved without first-stage edge");

    a_b_output_off: assert property (
        reg_file_reg[SLOT_OUT_MODE[3:0]][0] && !reg_file_reg[SLOT_OUT_MODE[3:0]][B_EN_LSB]
        ##1 reg_file_reg[SLOT_OUT_MODE[3:0]][0] |-> !out_b_reg[0])
        else $error("single-ended B driven while off");

endmodule // cdpo_channel_divider

// ===== dv/cdpo_clock_sink.sv
// downstream clock sink: period and high time of one output, in input cycles
// assumes dist_clk is a level synchronous to clock
`timescale 1ns/1ps
module cdpo_clock_sink (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic dist_clk,
    input  wire logic clk_seen,
    output int        period,
    output int        high_len,
    output int        last_rise
);
    int   in_cnt;
    logic dist_q;
    logic seen_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            {in_cnt, period, high_len, last_rise, dist_q, seen_q} <= '0;
        end else begin
            dist_q <= dist_clk;
            seen_q <= clk_seen;
            if (dist_clk && !dist_q) in_cnt <= in_cnt + 1;
            if (clk_seen && !seen_q) begin
                period    <= in_cnt - last_rise;
                last_rise <= in_cnt;
            end
            if (!clk_seen && seen_q) high_len <= in_cnt - last_rise;
        end
    end
endmodule // cdpo_clock_sink

// ===== dv/channel_divider_phase_offset_bench.sv
// bench: register access over Avalon-MM, divider ratios, duty and phase steps
// assumes one divider input cycle is four system clocks
`timescale 1ns/1ps
module channel_divider_phase_offset_bench import cdpo_pkg::*;;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [10:0] address = '0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  ph = 2'h0;
    logic        div0_out;
    logic        div1_out;
    logic [3:0]  outs_a;
    logic [3:0]  outs_b;
    logic [31:0] rd;
    int          n_errors = 0;
    int          tests_run = 0;
    int          per [4];
    int          hi [4];
    int          last [4];
    wire  logic  [3:0] seen = {outs_a[2], outs_a[0], div1_out, div0_out};
    wire  logic  dist_clk_in = ph[1];
    logic [7:0]  ofs [3] = '{8'h03, 8'h12, 8'h10};
    int          dly [3] = '{3, 18 - 16 + 7 + 1, 16 - 16 + 7 + 1};
    logic [7:0]  s1 [5] = '{8'h10, 8'h10, 8'h10, 8'h21, 8'h12};
    logic [7:0]  byp [5] = '{8'h00, 8'h20, 8'h30, 8'h20, 8'h20};
    int          eper [5] = '{6, 3, 1, 5, 5};
    int          ehi [5] = '{3, 1, 0, 2, 3};
    initial forever #50 clock = ~clock;
    always @(posedge clock) ph <= ph + 2'h1;
    cdpo_channel_divider i_cdpo_channel_divider (.clock(clock), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
        .waitrequest(waitrequest), .dist_clk_in(dist_clk_in), .div0_out(div0_out), .div1_out(div1_out),
        .differential_outputs_a(outs_a), .differential_outputs_b(outs_b));
    for (genvar g = 0; g < 4; g++) begin : g_sink
        cdpo_clock_sink i_cdpo_clock_sink (.clock(clock), .reset_n(reset_n), .dist_clk(dist_clk_in),
            .clk_seen(seen[g]), .period(per[g]), .high_len(hi[g]), .last_rise(last[g]));
    end
    task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] d);
        address   <= {idx, 2'b00};
        writedata <= {24'h0, d};
        read      <= !wr;
        write     <= wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // phase of divider 1 behind divider 0, both running at ratio 16
    function automatic int diff();
        return ((last[1] - last[0]) % 16 + 16) % 16;
    endfunction
    initial begin
        repeat (30000) @(posedge clock);
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        bus(1'b0, IDX_DIV2_DUTY, 8'h00);
        chk("duty_ctrl reset", 32'h0, rd);
        bus(1'b1, 9'h1FF, 8'hFF);
        bus(1'b0, 9'h1FF, 8'h00);
        chk("unmapped read", 32'h0, rd);
        // equal fields keep duty fix valid
        bus(1'b1, IDX_DIV0_CYC, 8'h77);
        bus(1'b1, IDX_DIV1_CYC, 8'h77);
        bus(1'b0, IDX_DIV1_CYC, 8'h00);
        chk("div1 counts", 32'h77, rd);
        bus(1'b1, IDX_SYNC_CTRL, 8'h01);
        repeat (300) @(posedge clock);
        bus(1'b1, IDX_DIV1_OFS, 8'h03);
        repeat (300) @(posedge clock);
        chk("offset before sync", 0, diff());
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, IDX_DIV1_OFS, ofs[k]);
            bus(1'b1, IDX_SYNC_CTRL, 8'h01);
            repeat (300) @(posedge clock);
            chk("phase step", dly[k], diff());
        end
        bus(1'b1, IDX_DIV0_CYC, 8'h21);
        repeat (300) @(posedge clock);
        chk("div0 period", 5, per[0]);
        chk("div0 high fixed", 2, hi[0]);
        bus(1'b1, IDX_DIV0_DUTY, 8'h01);
        bus(1'b1, IDX_DIV0_CYC, 8'h12);
        repeat (300) @(posedge clock);
        chk("div0 period raw", 5, per[0]);
        chk("div0 high raw", 3, hi[0]);
        bus(1'b1, IDX_DIV0_OFS, 8'h80);
        repeat (100) @(posedge clock);
        chk("div0 bypass", 1, per[0]);
        chk("div3 period", 4, per[3]);
        chk("div3 high", 2, hi[3]);
        // stage 1 used first, second bypassed when alone
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, IDX_DIV2_S1, s1[k]);
            bus(1'b1, IDX_DIV2_BYP, byp[k]);
            bus(1'b1, IDX_DIV2_DUTY, (k == 4) ? 8'h01 : 8'h00);
            repeat (300) @(posedge clock);
            chk("div2 period", eper[k], per[2]);
            if (k != 2) chk("div2 high", ehi[k], hi[2]);
        end
        chk("b differential", {31'h0, ~outs_a[0]}, {31'h0, outs_b[0]});
        bus(1'b1, IDX_OUT_MODE, 8'h01);
        repeat (4) @(posedge clock);
        chk("b off", 32'h0, {31'h0, outs_b[0]});
        bus(1'b1, IDX_OUT_MODE, 8'h11);
        repeat (4) @(posedge clock);
        chk("b on", {31'h0, outs_a[0]}, {31'h0, outs_b[0]});
        print_verdict();
    end
endmodule // channel_divider_phase_offset_bench
